// ==== core/dts_pkg.sv ====
`default_nettype none
package dts_pkg;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned NUM_SRC = 16;

  // trigger selector codes
  localparam logic [3:0] SEL_SOFTWARE = 4'h0;
  localparam logic [3:0] SEL_TA_CMP2 = 4'h1;
  localparam logic [3:0] SEL_TB_CMP2 = 4'h2;
  localparam logic [3:0] SEL_PORT0_RX = 4'h3;
  localparam logic [3:0] SEL_PORT0_TX = 4'h4;
  localparam logic [3:0] SEL_DAC0 = 4'h5;
  localparam logic [3:0] SEL_ADC_DONE = 4'h6;
  localparam logic [3:0] SEL_TA_CMP0 = 4'h7;
  localparam logic [3:0] SEL_TB_CMP0 = 4'h8;
  localparam logic [3:0] SEL_PORT1_RX = 4'h9;
  localparam logic [3:0] SEL_PORT1_TX = 4'hA;
  localparam logic [3:0] SEL_MULT_READY = 4'hB;
  localparam logic [3:0] SEL_NONE_C = 4'hC;
  localparam logic [3:0] SEL_NONE_D = 4'hD;
  localparam logic [3:0] SEL_CHAIN = 4'hE;
  localparam logic [3:0] SEL_EXTERNAL = 4'hF;

  // transfer mode field: low two bits zero means single transfer
  localparam logic [1:0] MODE_SINGLE_LOW = 2'h0;

  // reset values
  localparam logic [2:0] CH_ZERO = 3'h0;
  localparam logic [15:0] SRC_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    DTS_IDLE = 3'b001,
    DTS_WAIT_FETCH = 3'b010,
    DTS_HALTED = 3'b100
  } dts_halt_t;
endpackage
`default_nettype wire

// ==== core/dts_sense.sv ====
`default_nettype none
module dts_sense (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // selected trigger
  input wire logic [dts_pkg::SEL_W-1:0] sel,
  input wire logic trig_in,
  // sensed trigger
  output logic edge_seen,
  output logic level_seen
);
  import dts_pkg::*;

  typedef struct packed {
    logic prev;
    logic [SEL_W-1:0] sel_prev;
    logic edge_hit;
    logic level;
  } dts_sense_t;

  dts_sense_t st_r;
  dts_sense_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = trig_in;
    st_nxt.sel_prev = sel;
    // an edge only counts when the same source was low before, so a
    // source already high at selection time does not fire
    st_nxt.edge_hit = trig_in & ~st_r.prev & (sel == st_r.sel_prev);
    st_nxt.level = trig_in;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_seen = st_r.edge_hit;
  assign level_seen = st_r.level;
endmodule
`default_nettype wire

// ==== core/dts_top.sv ====
`default_nettype none
// Notes on behaviour
// - edge mode: transfer starts on rising edge of selected trigger only
// - edge mode: single uses one edge per unit, block one edge per block
// - level mode: keep requesting while trigger high and channel enabled
// - level mode: trigger low during block freezes channel until high again
// - halt_after_fetch clear: halt processor at once on trigger
// - halt_after_fetch set: let current instruction finish, then halt
// - code 0000: software_request triggers, cleared at transfer start
// - codes 0001/0111: timer A compare flags, auto-clear, masked by enable
// - codes 0010/1000: timer B compare flags, auto-clear, masked by enable
// - code 0011 two-wire: data-received condition, flag untouched, masked
// - code 0011 async/sync: port0 receive flag, auto-clear, masked
// - code 0100 two-wire: transmit-ready condition, flag untouched, masked
// - code 0100 async/sync: port0 transmit flag, auto-clear, masked
// - code 0101: converter channel 0 flag, auto-clear, masked by enable
// - code 0110: hardware conversion completion triggers, software set not
// - each adc completion flag clears when its result register is read
// - codes 1001/1010: port1 receive/transmit flags, auto-clear, masked
// - code 1111: external trigger pin is the source
// - codes 1100 and 1101 never trigger
// - code 1110: previous channel's done flag triggers, never auto-cleared
// - code 1011: multiplier ready for new operand triggers
module dts_top #(
  parameter int unsigned ADC_CH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // per-channel configuration
  input wire logic [dts_pkg::NUM_CH-1:0][dts_pkg::SEL_W-1:0] trigger_select_field,
  input wire logic [dts_pkg::NUM_CH-1:0][dts_pkg::MODE_W-1:0] transfer_mode_field,
  input wire logic [dts_pkg::NUM_CH-1:0] trigger_level_select,
  input wire logic [dts_pkg::NUM_CH-1:0] halt_after_fetch,
  input wire logic [dts_pkg::NUM_CH-1:0] channel_enable,
  input wire logic [dts_pkg::NUM_CH-1:0] software_request,
  input wire logic [dts_pkg::NUM_CH-1:0] config_write,
  // transfer engine
  input wire logic [dts_pkg::NUM_CH-1:0] transfer_start,
  input wire logic [dts_pkg::NUM_CH-1:0] block_active,
  input wire logic engine_busy,
  input wire logic adc_result_read,
  input wire logic [$clog2(ADC_CH)-1:0] adc_result_index,
  // timers
  input wire logic timer_a_compare2_flag,
  input wire logic timer_a_compare2_irq_enable,
  input wire logic timer_a_compare0_flag,
  input wire logic timer_a_compare0_irq_enable,
  input wire logic timer_b_compare2_flag,
  input wire logic timer_b_compare2_irq_enable,
  input wire logic timer_b_compare0_flag,
  input wire logic timer_b_compare0_irq_enable,
  // serial port 0
  input wire logic port0_twowire_mode,
  input wire logic twowire_rx_condition,
  input wire logic twowire_rx_ready_irq_enable,
  input wire logic twowire_tx_condition,
  input wire logic twowire_tx_ready_irq_enable,
  input wire logic port0_rx_flag,
  input wire logic port0_rx_irq_enable,
  input wire logic port0_tx_flag,
  input wire logic port0_tx_irq_enable,
  // serial port 1
  input wire logic port1_rx_flag,
  input wire logic port1_rx_irq_enable,
  input wire logic port1_tx_flag,
  input wire logic port1_tx_irq_enable,
  // converters, multiplier, chaining, pin
  input wire logic dac_done_flag,
  input wire logic dac_irq_enable,
  input wire logic adc_conversion_done,
  input wire logic multiplier_ready,
  input wire logic [dts_pkg::NUM_CH-1:0] channel_done_flag,
  input wire logic external_trigger_input,
  // processor halt control
  input wire logic instruction_fetch,
  output logic cpu_halt,
  output logic transfer_permit,
  // requests to the transfer engine
  output logic [dts_pkg::NUM_CH-1:0] trigger_request,
  output logic [dts_pkg::NUM_CH-1:0] channel_hold,
  // flag clears back to sources
  output logic [dts_pkg::NUM_CH-1:0] software_request_clear,
  output logic [dts_pkg::NUM_SRC-1:0] source_flag_clear,
  output logic [ADC_CH-1:0] adc_done_flag_clear
);
  import dts_pkg::*;

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic [NUM_CH-1:0] pending;
    logic [NUM_CH-1:0] req;
    logic [NUM_CH-1:0] hold;
    dts_halt_t halt;
    logic cpu_halt;
    logic permit;
    logic [NUM_CH-1:0] sw_clear;
    logic [NUM_SRC-1:0] src_clear;
    logic [ADC_CH-1:0] adc_clear;
  } dts_top_t;

  dts_top_t st_r;
  dts_top_t st_nxt;

  logic [NUM_SRC-1:0] src_vec;
  logic [NUM_CH-1:0] trig_sel;
  logic [NUM_CH-1:0] edge_seen;
  logic [NUM_CH-1:0] level_seen;

  // shared sources, indexed by selector code; chain and software are per channel
  always_comb begin
    src_vec = SRC_ZERO;
    src_vec[SEL_TA_CMP2] = timer_a_compare2_flag & ~timer_a_compare2_irq_enable;
    src_vec[SEL_TA_CMP0] = timer_a_compare0_flag & ~timer_a_compare0_irq_enable;
    src_vec[SEL_TB_CMP2] = timer_b_compare2_flag & ~timer_b_compare2_irq_enable;
    src_vec[SEL_TB_CMP0] = timer_b_compare0_flag & ~timer_b_compare0_irq_enable;
    if (port0_twowire_mode) begin
      src_vec[SEL_PORT0_RX] = twowire_rx_condition & ~twowire_rx_ready_irq_enable;
      src_vec[SEL_PORT0_TX] = twowire_tx_condition & ~twowire_tx_ready_irq_enable;
    end else begin
      src_vec[SEL_PORT0_RX] = port0_rx_flag & ~port0_rx_irq_enable;
      src_vec[SEL_PORT0_TX] = port0_tx_flag & ~port0_tx_irq_enable;
    end
    src_vec[SEL_DAC0] = dac_done_flag & ~dac_irq_enable;
    // only the converter's own completion event, never the flag bit itself
    src_vec[SEL_ADC_DONE] = adc_conversion_done;
    src_vec[SEL_PORT1_RX] = port1_rx_flag & ~port1_rx_irq_enable;
    src_vec[SEL_PORT1_TX] = port1_tx_flag & ~port1_tx_irq_enable;
    src_vec[SEL_MULT_READY] = multiplier_ready;
    src_vec[SEL_NONE_C] = 1'b0;
    src_vec[SEL_NONE_D] = 1'b0;
    src_vec[SEL_EXTERNAL] = st_r.ext_s2;
  end

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      always_comb begin
        if (trigger_select_field[gc] == SEL_SOFTWARE) begin
          trig_sel[gc] = software_request[gc];
        end else if (trigger_select_field[gc] == SEL_CHAIN) begin
          trig_sel[gc] = channel_done_flag[(gc + NUM_CH - 1) % NUM_CH];
        end else begin
          trig_sel[gc] = src_vec[trigger_select_field[gc]];
        end
      end

      dts_sense u_sense (
        .clock(clock),
        .rst(rst),
        .sel(trigger_select_field[gc]),
        .trig_in(trig_sel[gc]),
        .edge_seen(edge_seen[gc]),
        .level_seen(level_seen[gc])
      );
    end
  endgenerate

  always_comb begin
    logic any_req;
    logic any_now;
    logic is_single;
    any_req = 1'b0;
    any_now = 1'b0;
    is_single = 1'b0;
    st_nxt = st_r;
    st_nxt.ext_s1 = external_trigger_input;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.sw_clear = CH_ZERO;
    st_nxt.src_clear = SRC_ZERO;
    st_nxt.adc_clear = '0;

    for (int c = 0; c < NUM_CH; c++) begin
      is_single = (transfer_mode_field[c][1:0] == MODE_SINGLE_LOW);
      // in block mode, edges arriving during a block are ignored; a new edge wins over the
      // start that consumes the previous one
      if (transfer_start[c] || !channel_enable[c]) begin
        st_nxt.pending[c] = 1'b0;
      end
      if (edge_seen[c] && channel_enable[c] && (is_single || !block_active[c])) begin
        st_nxt.pending[c] = 1'b1;
      end
      if (trigger_level_select[c]) begin
        st_nxt.pending[c] = 1'b0;
        st_nxt.req[c] = level_seen[c] & channel_enable[c];
        // freeze while low mid-block; a register rewrite releases the freeze
        st_nxt.hold[c] = block_active[c] & ~level_seen[c] & ~config_write[c];
      end else begin
        st_nxt.req[c] = st_nxt.pending[c];
        st_nxt.hold[c] = 1'b0;
      end

      // flag clears at transfer start for the channel's selected source
      if (transfer_start[c]) begin
        if (trigger_select_field[c] == SEL_SOFTWARE) begin
          st_nxt.sw_clear[c] = 1'b1;
        end else if (trigger_select_field[c] == SEL_PORT0_RX ||
                     trigger_select_field[c] == SEL_PORT0_TX) begin
          st_nxt.src_clear[trigger_select_field[c]] = ~port0_twowire_mode;
        end else if (trigger_select_field[c] == SEL_TA_CMP2 ||
                     trigger_select_field[c] == SEL_TA_CMP0 ||
                     trigger_select_field[c] == SEL_TB_CMP2 ||
                     trigger_select_field[c] == SEL_TB_CMP0 ||
                     trigger_select_field[c] == SEL_DAC0 ||
                     trigger_select_field[c] == SEL_PORT1_RX ||
                     trigger_select_field[c] == SEL_PORT1_TX) begin
          st_nxt.src_clear[trigger_select_field[c]] = 1'b1;
        end
        // chain, adc, multiplier and pin sources are never cleared here
      end

      if (st_nxt.req[c]) begin
        any_req = 1'b1;
        if (!halt_after_fetch[c]) begin
          any_now = 1'b1;
        end
      end
    end

    if (adc_result_read) begin
      st_nxt.adc_clear[adc_result_index] = 1'b1;
    end

    case (st_r.halt)
      DTS_IDLE: begin
        if (any_now) begin
          st_nxt.halt = DTS_HALTED;
        end else if (any_req) begin
          st_nxt.halt = DTS_WAIT_FETCH;
        end
      end
      DTS_WAIT_FETCH: begin
        if (any_now || instruction_fetch) begin
          st_nxt.halt = DTS_HALTED;
        end else if (!any_req) begin
          st_nxt.halt = DTS_IDLE;
        end
      end
      DTS_HALTED: begin
        if (!any_req && !engine_busy) begin
          st_nxt.halt = DTS_IDLE;
        end
      end
      default: begin
        st_nxt.halt = DTS_IDLE;
      end
    endcase
    st_nxt.cpu_halt = (st_nxt.halt == DTS_HALTED);
    st_nxt.permit = (st_nxt.halt == DTS_HALTED);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{halt: DTS_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_halt = st_r.cpu_halt;
  assign transfer_permit = st_r.permit;
  assign trigger_request = st_r.req;
  assign channel_hold = st_r.hold;
  assign software_request_clear = st_r.sw_clear;
  assign source_flag_clear = st_r.src_clear;
  assign adc_done_flag_clear = st_r.adc_clear;
endmodule
`default_nettype wire

// ==== testbench/dts_top_checker.sv ====
`default_nettype none
module dts_top_checker #(
  parameter int unsigned ADC_CH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // configuration and engine
  input wire logic [dts_pkg::NUM_CH-1:0][dts_pkg::SEL_W-1:0] trigger_select_field,
  input wire logic [dts_pkg::NUM_CH-1:0] trigger_level_select,
  input wire logic [dts_pkg::NUM_CH-1:0] halt_after_fetch,
  input wire logic [dts_pkg::NUM_CH-1:0] channel_enable,
  input wire logic [dts_pkg::NUM_CH-1:0] config_write,
  input wire logic [dts_pkg::NUM_CH-1:0] transfer_start,
  input wire logic [dts_pkg::NUM_CH-1:0] block_active,
  input wire logic adc_result_read,
  input wire logic [$clog2(ADC_CH)-1:0] adc_result_index,
  // sources
  input wire logic timer_a_compare2_flag,
  input wire logic timer_a_compare2_irq_enable,
  input wire logic external_trigger_input,
  input wire logic instruction_fetch,
  // outputs
  input wire logic cpu_halt,
  input wire logic [dts_pkg::NUM_CH-1:0] trigger_request,
  input wire logic [dts_pkg::NUM_CH-1:0] channel_hold,
  input wire logic [dts_pkg::NUM_CH-1:0] software_request_clear,
  input wire logic [dts_pkg::NUM_SRC-1:0] source_flag_clear,
  input wire logic [ADC_CH-1:0] adc_done_flag_clear
);
  import dts_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_ta2_rise;
    !trigger_level_select[0] && channel_enable[0] && !block_active[0] &&
      trigger_select_field[0] == SEL_TA_CMP2 && $stable(trigger_select_field[0]) &&
      !timer_a_compare2_irq_enable && $rose(timer_a_compare2_flag);
  endsequence
  a_edge_start: assert property (s_ta2_rise |-> ##[2:3] trigger_request[0])
    else $error("edge gave no request");
  a_sw_clear: assert property (software_request_clear[0] |-> $past(transfer_start[0]) &&
    $past(trigger_select_field[0]) == SEL_SOFTWARE ##1 !software_request_clear[0])
    else $error("software clear out of place");
  a_flag_clear: assert property (transfer_start[0] &&
    trigger_select_field[0] == SEL_TA_CMP2 |=> source_flag_clear[SEL_TA_CMP2] ##1
    !source_flag_clear[SEL_TA_CMP2]) else $error("timer flag clear wrong");
  a_never_clear: assert property (!source_flag_clear[SEL_CHAIN])
    else $error("chain flag cleared");
  a_dead_codes: assert property (((trigger_select_field[0] == SEL_NONE_C ||
    trigger_select_field[0] == SEL_NONE_D) && !trigger_request[0])[*3] |=>
    !trigger_request[0]) else $error("dead code triggered");
  a_adc_clear: assert property (adc_result_read |=> $onehot(adc_done_flag_clear) &&
    adc_done_flag_clear[$past(adc_result_index)]) else $error("adc clear wrong");
  a_halt_now: assert property ($rose(trigger_request[0]) && !halt_after_fetch[0] |->
    cpu_halt) else $error("halt late");
  a_halt_fetch: assert property ($rose(cpu_halt) && halt_after_fetch[0] &&
    trigger_request[0] |-> $past(instruction_fetch)) else $error("halt before fetch");
  a_level_run: assert property ((trigger_level_select[0] && channel_enable[0] &&
    trigger_select_field[0] == SEL_EXTERNAL && external_trigger_input)[*6] |->
    trigger_request[0]) else $error("level request missing");
  a_level_hold: assert property ((trigger_level_select[0] && block_active[0] &&
    !config_write[0] && trigger_select_field[0] == SEL_EXTERNAL &&
    !external_trigger_input)[*6] |-> channel_hold[0]) else $error("no hold");
endmodule
bind dts_top dts_top_checker #(.ADC_CH(ADC_CH)) u_chk (.*);
`default_nettype wire

// ==== testbench/dts_partner.sv ====
`default_nettype none
module dts_partner (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // peripheral flags
  input wire logic [15:0] flag_set,
  input wire logic [15:0] flag_clear,
  input wire logic [15:0] source_flag_clear,
  output logic [15:0] flags,
  // transfer engine
  input wire logic stall,
  input wire logic [dts_pkg::NUM_CH-1:0] trigger_request,
  output logic [dts_pkg::NUM_CH-1:0] transfer_start,
  output logic engine_busy
);
  import dts_pkg::*;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags <= SRC_ZERO;
      transfer_start <= CH_ZERO;
      engine_busy <= 1'b0;
    end else begin
      flags <= (flags | flag_set) & ~(source_flag_clear | flag_clear);
      // stall keeps requests waiting, as a slow engine would
      transfer_start <= trigger_request & ~transfer_start & {NUM_CH{~(engine_busy | stall)}};
      engine_busy <= |transfer_start;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dts_pkg::*;
  logic clock, rst, twm, ext, ard, ifet, stall, seen, fr, cl, halt, perm, busy, g;
  logic [3:0] code, aix;
  logic [NUM_CH-1:0][SEL_W-1:0] tsf;
  logic [NUM_CH-1:0][MODE_W-1:0] tmf;
  logic [NUM_CH-1:0] lvl, hf, en, sw, cw, ba, done, ts, req, hold, swc;
  logic [15:0] ie, setf, clrf, flg, sfc, adcc;
  int n_mismatch = 0;
  int checks = 0;
  // code, fires, source cleared afterwards
  logic [5:0] rows [16] = '{6'h03, 6'h07, 6'h0B, 6'h0F, 6'h13, 6'h17, 6'h1A, 6'h1F,
    6'h23, 6'h27, 6'h2B, 6'h2E, 6'h30, 6'h34, 6'h3A, 6'h3E};
  dts_top #(.ADC_CH(16)) dut (.clock(clock), .rst(rst), .trigger_select_field(tsf),
    .transfer_mode_field(tmf), .trigger_level_select(lvl), .halt_after_fetch(hf),
    .channel_enable(en), .software_request({sw[2:1], flg[0]}), .config_write(cw),
    .transfer_start(ts), .block_active(ba), .engine_busy(busy), .adc_result_read(ard),
    .adc_result_index(aix),
    .timer_a_compare2_flag(flg[1]), .timer_a_compare2_irq_enable(ie[1]),
    .timer_a_compare0_flag(flg[7]), .timer_a_compare0_irq_enable(ie[7]),
    .timer_b_compare2_flag(flg[2]), .timer_b_compare2_irq_enable(ie[2]),
    .timer_b_compare0_flag(flg[8]), .timer_b_compare0_irq_enable(ie[8]),
    .port0_twowire_mode(twm), .twowire_rx_condition(flg[12]),
    .twowire_rx_ready_irq_enable(ie[12]), .twowire_tx_condition(flg[13]),
    .twowire_tx_ready_irq_enable(ie[13]), .port0_rx_flag(flg[3]),
    .port0_rx_irq_enable(ie[3]), .port0_tx_flag(flg[4]), .port0_tx_irq_enable(ie[4]),
    .port1_rx_flag(flg[9]), .port1_rx_irq_enable(ie[9]), .port1_tx_flag(flg[10]),
    .port1_tx_irq_enable(ie[10]), .dac_done_flag(flg[5]), .dac_irq_enable(ie[5]),
    .adc_conversion_done(flg[6]), .multiplier_ready(flg[11]), .channel_done_flag(done),
    .external_trigger_input(ext), .instruction_fetch(ifet), .cpu_halt(halt),
    .transfer_permit(perm), .trigger_request(req), .channel_hold(hold),
    .software_request_clear(swc), .source_flag_clear(sfc), .adc_done_flag_clear(adcc));
  dts_partner peer (.clock(clock), .rst(rst), .flag_set(setf), .flag_clear(clrf),
    .source_flag_clear({sfc[15:1], sfc[0] | swc[0]}), .flags(flg), .stall(stall),
    .trigger_request(req), .transfer_start(ts), .engine_busy(busy));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // channel 0 software bit lives in the flag model at index 0, cleared by its pulse
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_req(input logic must, output logic s);
    s = 1'b0;
    for (int i = 0; i < 10 && !s; i++) begin
      @(negedge clock);
      s = req[0];
    end
    if (must && !s) begin
      n_mismatch++;
      $display("[FAIL] request wait expected 1 seen 0");
      complete_run();
    end
  endtask
  task automatic fire(logic [3:0] c);
    case (c)
      SEL_CHAIN: done[2] = 1'b1;
      SEL_EXTERNAL: ext = 1'b1;
      default: setf[c] = 1'b1;
    endcase
    @(negedge clock);
    setf = 16'h0000;
  endtask
  task automatic arm(logic [3:0] c);
    tsf[0] = c;
    repeat (3) @(negedge clock);
    fire(c);
  endtask
  task automatic tidy(string nm);
    // flags drop before their masks, so no unmasked rise is left behind
    clrf = 16'hFFFF;
    @(negedge clock);
    {done, ext, sw, ie, twm} = '0;
    clrf = 16'h0000;
    repeat (2) @(negedge clock);
    $display("%s done", nm);
  endtask
  initial begin
    {rst, twm, ext, ard, ifet, stall} = 6'h20;
    {tsf, tmf, lvl, hf, sw, cw, ba, done, ie, setf, clrf, aix} = '0;
    en = 3'h1;
    repeat (2) @(negedge clock);
    chk("reset outputs", 16'h0000, 16'({req, hold, swc, halt, perm}));
    repeat (2) @(negedge clock);
    rst = 1'b0;
    foreach (rows[k]) begin
      {code, fr, cl} = rows[k];
      arm(code);
      wait_req(fr, seen);
      chk("request", 16'(fr), 16'(seen));
      chk("halt", 16'(fr), {15'h0, halt & perm});
      repeat (6) @(negedge clock);
      chk("rerequest", 16'h0000, 16'(req[0]));
      g = code == 14 ? done[2] : code == 15 ? ext : flg[code];
      chk("source after start", 16'(!cl), 16'(g));
      tidy("row");
    end
    ie[1] = 1'b1;
    arm(SEL_TA_CMP2);
    wait_req(1'b0, seen);
    chk("masked source", 16'h0000, 16'(seen));
    tidy("masked");
    twm = 1'b1;
    arm(SEL_PORT0_RX);
    wait_req(1'b0, seen);
    chk("flag in two-wire", 16'h0000, 16'(seen));
    fire(SEL_NONE_C);
    wait_req(1'b1, seen);
    repeat (4) @(negedge clock);
    chk("two-wire flag kept", 16'h0001, 16'(flg[3]));
    tidy("two-wire");
    {lvl[0], tmf[0], tsf[0]} = {1'b1, 3'h1, SEL_EXTERNAL};
    ext = 1'b1;
    wait_req(1'b1, seen);
    repeat (4) @(negedge clock);
    chk("level request", 16'h0001, 16'(req[0]));
    {ba[0], ext} = 2'h2;
    repeat (6) @(negedge clock);
    chk("hold", 16'h0001, 16'(hold[0]));
    ext = 1'b1;
    repeat (6) @(negedge clock);
    chk("resume", 16'h0000, 16'(hold[0]));
    ext = 1'b0;
    repeat (6) @(negedge clock);
    cw[0] = 1'b1;
    @(negedge clock);
    chk("rewrite release", 16'h0000, 16'(hold[0]));
    {cw[0], ba[0]} = 2'h0;
    @(negedge clock);
    {lvl[0], tmf[0]} = 4'h0;
    tidy("level");
    {hf[0], stall} = 2'h3;
    arm(SEL_SOFTWARE);
    wait_req(1'b1, seen);
    repeat (3) @(negedge clock);
    chk("halt before fetch", 16'h0002, 16'({req[0], halt}));
    ifet = 1'b1;
    @(negedge clock);
    ifet = 1'b0;
    @(negedge clock);
    chk("halt after fetch", 16'h0001, 16'(halt));
    {hf[0], stall} = 2'h0;
    repeat (4) @(negedge clock);
    chk("software bit", 16'h0000, 16'(flg[0]));
    tidy("fetch");
    // source already high when it becomes selected
    fire(SEL_TA_CMP2);
    tsf[0] = SEL_TA_CMP2;
    wait_req(1'b0, seen);
    chk("preset source", 16'h0000, 16'(seen));
    tidy("preset");
    // block mode ignores edges while a block runs
    {tmf[0], ba[0]} = 4'h3;
    arm(SEL_TA_CMP2);
    wait_req(1'b0, seen);
    chk("edge in block", 16'h0000, 16'(seen));
    {tmf[0], ba[0]} = 4'h0;
    tidy("block");
    aix = 4'h5;
    ard = 1'b1;
    @(negedge clock);
    ard = 1'b0;
    chk("adc clear", 16'h0020, adcc);
    $display("adc done");
    complete_run();
  end
endmodule
`default_nettype wire
